// >>> inc/fsr_cfg.svh
// Constants for the field sensor readout: command byte layout, widths and ratios
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// Command byte field positions, most significant first on the wire
`define FSR_CMD_BITS        8
`define FSR_CMD_CLK_TEST    7
`define FSR_CMD_DIV_HI      6
`define FSR_CMD_DIV_LO      4
`define FSR_CMD_OSC_DIR     3
`define FSR_CMD_OSC_TEST    2
`define FSR_CMD_AXIS_HI     1
`define FSR_CMD_AXIS_LO     0
`define FSR_CMD_RESET_VAL   8'h00

// Axis select codes; the other two codes are undefined
`define FSR_AXIS_X          2'h1
`define FSR_AXIS_Y          2'h2

// Result word and shift counters
`define FSR_RESULT_BITS     16
`define FSR_TX_CNT_W        5
`define FSR_RX_CNT_W        4

// Divider: code 0 is /32, each code step doubles, code 7 is /4096
`define FSR_DIV_W           3
`define FSR_PERIOD_W        13
`define FSR_DIV_BASE        13'h0020

`endif

// >>> inc/fsr_pkg.sv
// Types shared by the field sensor readout modules
package fsr_pkg;

  // Top-level sequencer states
  typedef enum logic [2:0] {
    FSR_ST_WAIT_CMD = 3'b000,
    FSR_ST_FWD      = 3'b001,
    FSR_ST_REV      = 3'b010,
    FSR_ST_READY    = 3'b011,
    FSR_ST_OSC_TEST = 3'b100,
    FSR_ST_HALT     = 3'b101
  } fsr_state_t;

  // Serial port pins from the host, active-low select
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic slave_select_n;
  } fsr_spi_in_t;

  // Decoded command byte
  typedef struct packed {
    logic       hs_clock_test;
    logic [2:0] divider_sel;
    logic       osc_direction;
    logic       osc_test_run;
    logic [1:0] axis_sel;
  } fsr_cmd_t;

  // Drive toward the sensor oscillators
  typedef struct packed {
    logic run_x;
    logic run_y;
    logic bias_rev;
  } fsr_osc_drive_t;

endpackage

// >>> verilog/fsr_cmd_rx.sv
// Command byte receiver: samples the master-out line on serial clock rises
`timescale 1ns/1ps
`include "fsr_cfg.svh"

module fsr_cmd_rx (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  enable,
  input  wire fsr_pkg::fsr_spi_in_t  spi,
  output fsr_pkg::fsr_cmd_t          cmd,
  output logic                       cmd_valid
);

  typedef struct packed {
    logic                     sclk_prev;
    logic [`FSR_RX_CNT_W-1:0] bit_cnt;
    logic [`FSR_CMD_BITS-1:0] shift;
    logic [`FSR_CMD_BITS-1:0] cmd;
    logic                     valid;
  } fsr_rx_state_t;

  fsr_rx_state_t st;
  fsr_rx_state_t next_st;
  logic          sclk_rise;

  // Capture on rising edge while selected
  assign sclk_rise = spi.sclk & ~st.sclk_prev & ~spi.slave_select_n;

  always_comb begin
    next_st           = st;
    next_st.sclk_prev = spi.sclk;
    next_st.valid     = 1'b0;
    if (spi.slave_select_n || !enable) begin
      next_st.bit_cnt = '0;
    end else if (sclk_rise) begin
      next_st.shift = {st.shift[`FSR_CMD_BITS-2:0], spi.mosi};
      if (st.bit_cnt == `FSR_RX_CNT_W'(`FSR_CMD_BITS - 1)) begin
        next_st.bit_cnt = '0;
        next_st.cmd     = {st.shift[`FSR_CMD_BITS-2:0], spi.mosi};
        next_st.valid   = 1'b1;
      end else begin
        next_st.bit_cnt = st.bit_cnt + `FSR_RX_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st     <= '0;
      st.cmd <= `FSR_CMD_RESET_VAL;
    end else begin
      st <= next_st;
    end
  end

  assign cmd       = fsr_pkg::fsr_cmd_t'(st.cmd);
  assign cmd_valid = st.valid;

endmodule

// >>> verilog/fsr_period_counter.sv
// Period counter: counts internal clocks across a divided number of oscillator cycles
`timescale 1ns/1ps
`include "fsr_cfg.svh"

module fsr_period_counter #(
  parameter int CNT_W = 24
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  start,
  input  wire logic [`FSR_DIV_W-1:0] divider_sel,
  input  wire logic                  osc_in,
  output logic                       done,
  output logic [CNT_W-1:0]           count
);

  typedef struct packed {
    logic                     busy;
    logic                     armed;
    logic                     osc_prev;
    logic [`FSR_PERIOD_W-1:0] target;
    logic [`FSR_PERIOD_W-1:0] periods;
    logic [CNT_W-1:0]         count;
    logic                     done;
  } fsr_cnt_state_t;

  fsr_cnt_state_t st;
  fsr_cnt_state_t next_st;
  logic           osc_rise;

  assign osc_rise = osc_in & ~st.osc_prev;

  // Gate opens on the first oscillator rise, closes after target rises
  always_comb begin
    next_st          = st;
    next_st.osc_prev = osc_in;
    next_st.done     = 1'b0;
    if (start) begin
      next_st.busy    = 1'b1;
      next_st.armed   = 1'b0;
      next_st.periods = '0;
      next_st.count   = '0;
      next_st.target  = `FSR_DIV_BASE << divider_sel;
    end else if (st.busy) begin
      if (st.armed) begin
        next_st.count = st.count + CNT_W'(1);
      end
      if (osc_rise) begin
        if (!st.armed) begin
          next_st.armed = 1'b1;
        end else if (st.periods == st.target - `FSR_PERIOD_W'(1)) begin
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end else begin
          next_st.periods = st.periods + `FSR_PERIOD_W'(1);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done  = st.done;
  assign count = st.count;

endmodule

// >>> verilog/fsr_readout.sv
// Field sensor readout top: command decode, forward/reverse measurement, result shift-out
//
// Overview of operation
// - Ready low after reset, high when result available
// - Eight command bits start execution
// - Count forward, count reverse, report difference
// - Result shifts out on next sixteen clocks
// - Select high disables the serial port
// - Serial clock idles low, data stable high
// - Idle mode only reachable from a measurement
// - Select high after a measurement command enters idle mode
// - Ready rises without the result being read
// - One axis per command, 16-bit signed result
// - Command byte layout, all bits reset zero
// - Axis code 01 is X, 10 is Y
// - Oscillator test runs axis until reset
// - Direction bit only used in oscillator test
// - Clock test toggles output at half rate
// - Divider codes select /32 up to /4096
// - Serial data travels most significant first
// - Slave-out released while select is high
// - Master changes on fall, capture on rise
`timescale 1ns/1ps
`include "fsr_cfg.svh"

module fsr_readout #(
  parameter int CNT_W = 24
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire fsr_pkg::fsr_spi_in_t   spi,
  input  wire logic                   meas_reset,
  input  wire logic                   osc_x_comp,
  input  wire logic                   osc_y_comp,
  output logic                        miso,
  output logic                        miso_oe,
  output logic                        result_ready,
  output logic                        hs_clock_test,
  output logic                        idle_mode,
  output fsr_pkg::fsr_osc_drive_t     osc_drive
);

  // Whole module state in one record
  typedef struct packed {
    fsr_pkg::fsr_state_t           state;
    fsr_pkg::fsr_cmd_t             cmd;
    logic [CNT_W-1:0]              fwd_count;
    logic [`FSR_RESULT_BITS-1:0]   tx;
    logic [`FSR_TX_CNT_W-1:0]      tx_cnt;
    logic                          sclk_prev;
    logic                          start;
    logic                          ready;
    logic                          idle;
    logic                          hs;
    logic                          miso;
    logic                          miso_oe;
    fsr_pkg::fsr_osc_drive_t       drive;
  } fsr_top_state_t;

  fsr_top_state_t    st;
  fsr_top_state_t    next_st;

  // Block-wide clear: system reset or the host's measurement reset pulse
  logic              clear;
  logic              rx_enable;
  fsr_pkg::fsr_cmd_t rx_cmd;
  logic              rx_valid;
  logic              cnt_done;
  logic [CNT_W-1:0]  cnt_value;
  logic              osc_sel;
  logic              sclk_fall;
  logic              axis_ok;
  logic [CNT_W-1:0]  diff;

  // The host's pulse clears everything it touches, level-sensitive
  assign clear = reset | meas_reset;

  // Command bytes only accepted while waiting for one
  assign rx_enable = (st.state == fsr_pkg::FSR_ST_WAIT_CMD);

  fsr_cmd_rx u_cmd_rx (
    .mclk      (mclk),
    .reset     (clear),
    .enable    (rx_enable),
    .spi       (spi),
    .cmd       (rx_cmd),
    .cmd_valid (rx_valid)
  );

  // One counter shared by both bias phases and both axes
  assign osc_sel = st.drive.run_y ? osc_y_comp : osc_x_comp;

  fsr_period_counter #(
    .CNT_W (CNT_W)
  ) u_period_counter (
    .mclk        (mclk),
    .reset       (clear),
    .start       (st.start),
    .divider_sel (st.cmd.divider_sel),
    .osc_in      (osc_sel),
    .done        (cnt_done),
    .count       (cnt_value)
  );

  // Result changes on the falling clock so it is stable while high
  assign sclk_fall = ~spi.sclk & st.sclk_prev & ~spi.slave_select_n;

  // Only the two defined axis codes start a measurement
  assign axis_ok = (rx_cmd.axis_sel == `FSR_AXIS_X) || (rx_cmd.axis_sel == `FSR_AXIS_Y);

  // Difference wraps to 16 bits; large dividers in strong fields can overflow
  assign diff = st.fwd_count - cnt_value;

  // Sequencer and output shaping
  always_comb begin
    next_st           = st;
    next_st.sclk_prev = spi.sclk;
    next_st.start     = 1'b0;

    // Diagnostic clock: half rate when enabled, parked high otherwise
    if (st.cmd.hs_clock_test) begin
      next_st.hs = ~st.hs;
    end else begin
      next_st.hs = 1'b1;
    end

    // Slave-out drive follows the select line
    next_st.miso_oe = ~spi.slave_select_n;

    case (st.state)
      fsr_pkg::FSR_ST_WAIT_CMD: begin
        if (rx_valid) begin
          next_st.cmd = rx_cmd;
          if (!axis_ok) begin
            // Undefined axis: stay parked, ready held low
            next_st.state = fsr_pkg::FSR_ST_HALT;
          end else if (rx_cmd.osc_test_run) begin
            next_st.state          = fsr_pkg::FSR_ST_OSC_TEST;
            next_st.drive.run_x    = (rx_cmd.axis_sel == `FSR_AXIS_X);
            next_st.drive.run_y    = (rx_cmd.axis_sel == `FSR_AXIS_Y);
            next_st.drive.bias_rev = rx_cmd.osc_direction;
          end else begin
            // Normal measurement: forward bias first, one axis only
            next_st.state          = fsr_pkg::FSR_ST_FWD;
            next_st.start          = 1'b1;
            next_st.drive.run_x    = (rx_cmd.axis_sel == `FSR_AXIS_X);
            next_st.drive.run_y    = (rx_cmd.axis_sel == `FSR_AXIS_Y);
            next_st.drive.bias_rev = 1'b0;
          end
        end
      end

      fsr_pkg::FSR_ST_FWD: begin
        // Host may drop select once execution has begun
        if (spi.slave_select_n) begin
          next_st.idle = 1'b1;
        end
        if (cnt_done) begin
          next_st.fwd_count      = cnt_value;
          next_st.drive.bias_rev = 1'b1;
          next_st.start          = 1'b1;
          next_st.state          = fsr_pkg::FSR_ST_REV;
        end
      end

      fsr_pkg::FSR_ST_REV: begin
        if (spi.slave_select_n) begin
          next_st.idle = 1'b1;
        end
        if (cnt_done) begin
          // Oscillator stops; result loaded with MSB already on the line
          next_st.drive  = '0;
          next_st.tx     = diff[`FSR_RESULT_BITS-1:0];
          next_st.miso   = diff[`FSR_RESULT_BITS-1];
          next_st.tx_cnt = '0;
          next_st.ready  = 1'b1;
          next_st.state  = fsr_pkg::FSR_ST_READY;
        end
      end

      fsr_pkg::FSR_ST_READY: begin
        // Idle mode persists; readout is optional
        if (spi.slave_select_n) begin
          next_st.idle = 1'b1;
        end
        if (sclk_fall && st.tx_cnt != `FSR_TX_CNT_W'(`FSR_RESULT_BITS)) begin
          // After the sixteenth bit the line reads zero
          next_st.tx     = {st.tx[`FSR_RESULT_BITS-2:0], 1'b0};
          next_st.miso   = st.tx[`FSR_RESULT_BITS-2];
          next_st.tx_cnt = st.tx_cnt + `FSR_TX_CNT_W'(1);
        end
      end

      fsr_pkg::FSR_ST_OSC_TEST: begin
        // Oscillator keeps running; only a reset pulse leaves here
        next_st.state = fsr_pkg::FSR_ST_OSC_TEST;
      end

      fsr_pkg::FSR_ST_HALT: begin
        next_st.state = fsr_pkg::FSR_ST_HALT;
      end

      default: begin
        next_st.state = fsr_pkg::FSR_ST_WAIT_CMD;
      end
    endcase
  end

  // State register; the host pulse acts like reset, both applied on the clock
  always_ff @(posedge mclk) begin
    if (clear) begin
      st         <= '0;
      st.state   <= fsr_pkg::FSR_ST_WAIT_CMD;
      st.cmd     <= fsr_pkg::fsr_cmd_t'(`FSR_CMD_RESET_VAL);
      st.hs      <= 1'b1;
      st.miso_oe <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Every output straight from the state record
  assign miso          = st.miso;
  assign miso_oe       = st.miso_oe;
  assign result_ready  = st.ready;
  assign hs_clock_test = st.hs;
  assign idle_mode     = st.idle;
  assign osc_drive     = st.drive;

endmodule

// >>> test/fsr_osc_model.sv
// Behavioural sensor oscillator pair answering the readout's drive outputs
`timescale 1ns/1ps
module fsr_osc_model (
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire fsr_pkg::fsr_osc_drive_t drive,
  output logic                         osc_x_comp,
  output logic                         osc_y_comp
);
  logic [2:0] phase;
  logic [2:0] period;
  logic       wave;

  // X is faster forward, Y faster in reverse, so the sign tells the axes apart
  assign period = (drive.run_x ^ drive.bias_rev) ? 3'h4 : 3'h6;
  assign wave = (phase < (period >> 1));

  // Phase restarts whenever no axis runs; a stopped oscillator stays low
  always @(posedge mclk) begin
    if (reset || !(drive.run_x || drive.run_y))
      phase <= 3'h0;
    else if (phase >= period - 3'h1)
      phase <= 3'h0;
    else
      phase <= phase + 3'h1;
  end

  assign osc_x_comp = drive.run_x & wave;
  assign osc_y_comp = drive.run_y & wave;
endmodule

// >>> test/fsr_readout_asserts.sv
// Port checker for the field sensor readout top
`timescale 1ns/1ps
module fsr_readout_asserts #(
  parameter int CNT_W = 24
) (
  input wire logic                    mclk,
  input wire logic                    reset,
  input wire fsr_pkg::fsr_spi_in_t    spi,
  input wire logic                    meas_reset,
  input wire logic                    osc_x_comp,
  input wire logic                    osc_y_comp,
  input wire logic                    miso,
  input wire logic                    miso_oe,
  input wire logic                    result_ready,
  input wire logic                    hs_clock_test,
  input wire logic                    idle_mode,
  input wire fsr_pkg::fsr_osc_drive_t osc_drive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_mrst; meas_reset |=> !result_ready && osc_drive == 3'h0 && !idle_mode; endproperty
  a_mrst: assert property (p_mrst) else $error("measurement reset left state set");
  property p_hold; result_ready && !meas_reset |=> result_ready; endproperty
  a_hold: assert property (p_hold) else $error("ready dropped without reset");
  property p_oe; spi.slave_select_n |=> !miso_oe; endproperty
  a_oe: assert property (p_oe) else $error("slave-out driven while deselected");
  property p_idle_sel; $rose(idle_mode) |-> $past(spi.slave_select_n); endproperty
  a_idle_sel: assert property (p_idle_sel) else $error("idle entered while selected");
  property p_idle_src; $rose(idle_mode) |-> $past(osc_drive) != 3'h0 || $past(result_ready); endproperty
  a_idle_src: assert property (p_idle_src) else $error("idle entered with no measurement");
  // Half-rate toggle never leaves the pin low two cycles running
  property p_hs; !hs_clock_test |=> hs_clock_test; endproperty
  a_hs: assert property (p_hs) else $error("clock test pin low twice");
  property p_rdy_src; $rose(result_ready) |-> $past(osc_drive.bias_rev); endproperty
  a_rdy_src: assert property (p_rdy_src) else $error("ready without reverse phase");
  property p_axis; !(osc_drive.run_x && osc_drive.run_y); endproperty
  a_axis: assert property (p_axis) else $error("both axes driven");

  c_rdy: cover property ($rose(result_ready));
  c_idle: cover property ($rose(idle_mode));
  c_hs: cover property ($fell(hs_clock_test));
endmodule

bind fsr_readout fsr_readout_asserts #(.CNT_W(CNT_W)) i_chk (
  .mclk(mclk), .reset(reset), .spi(spi), .meas_reset(meas_reset), .osc_x_comp(osc_x_comp),
  .osc_y_comp(osc_y_comp), .miso(miso), .miso_oe(miso_oe), .result_ready(result_ready),
  .hs_clock_test(hs_clock_test), .idle_mode(idle_mode), .osc_drive(osc_drive));

// >>> test/tb_fsr_readout.sv
// Self-checking bench for the field sensor readout
`timescale 1ns/1ps
module tb_fsr_readout;
  logic                    mclk = 1'b0;
  logic                    reset = 1'b1;
  logic                    meas_reset = 1'b0;
  fsr_pkg::fsr_spi_in_t    spi = 3'b001;
  logic                    osc_x_comp, osc_y_comp;
  logic                    miso, miso_oe, result_ready, hs_clock_test, idle_mode;
  fsr_pkg::fsr_osc_drive_t osc_drive;
  int                      fail_count = 0;
  int                      checks_done = 0;
  int                      cycles = 0;
  logic [15:0]             rd;
  logic [15:0]             ex;
  logic                    hs_a;

  always #2.5 mclk = ~mclk;

  fsr_readout i_dut (.mclk(mclk), .reset(reset), .spi(spi), .meas_reset(meas_reset), .osc_x_comp(osc_x_comp),
    .osc_y_comp(osc_y_comp), .miso(miso), .miso_oe(miso_oe), .result_ready(result_ready),
    .hs_clock_test(hs_clock_test), .idle_mode(idle_mode), .osc_drive(osc_drive));
  fsr_osc_model i_osc (.mclk(mclk), .reset(reset), .drive(osc_drive), .osc_x_comp(osc_x_comp),
    .osc_y_comp(osc_y_comp));

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Data moves with the falling clock so it is steady across the rise
  task automatic spi_bit(input logic b);
    spi.sclk <= 1'b0;
    spi.mosi <= b;
    tick(3);
    spi.sclk <= 1'b1;
    tick(3);
  endtask

  // Select, pulse the measurement reset, then the command MSB first
  task automatic send_cmd(input logic [7:0] c);
    spi.slave_select_n <= 1'b0;
    tick(1);
    meas_reset <= 1'b1;
    tick(1);
    meas_reset <= 1'b0;
    tick(2);
    for (int i = 7; i >= 0; i--) spi_bit(c[i]);
    spi.sclk <= 1'b0;
    tick(4);
  endtask

  // Sample just before each rise; a long low phase covers the edge detect and output register
  task automatic read16(output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      @(negedge mclk) r[i] = miso;
      @(posedge mclk) spi.sclk <= 1'b1;
      tick(3);
      spi.sclk <= 1'b0;
      tick(6);
    end
  endtask

  task automatic wait_ready(input int lim);
    int k;
    k = 0;
    while (result_ready !== 1'b1 && k < lim) begin
      @(negedge mclk);
      k++;
    end
    chk(16'(result_ready), 16'h1);
    @(posedge mclk);
  endtask

  initial begin
    tick(8);
    reset <= 1'b0;
    tick(2);
    @(negedge mclk);
    chk(16'({result_ready, hs_clock_test, idle_mode, miso_oe, osc_drive}), 16'h0020);
    @(posedge mclk);
    // Every divider code; Y on one code, direction and clock test on others
    for (int d = 0; d < 8; d++) begin
      logic y;
      y = (d == 6);
      ex = 16'(64 << d);
      if (!y)
        ex = -ex;
      send_cmd({d == 1, 3'(d), d == 0, 1'b0, y, !y});
      @(negedge mclk);
      chk(16'(osc_drive), {13'h0, !y, y, 1'b0});
      hs_a = hs_clock_test;
      @(negedge mclk);
      chk(16'(hs_a ^ hs_clock_test), 16'(d == 1));
      if (d == 2) begin
        @(posedge mclk) spi.slave_select_n <= 1'b1;
        tick(3);
        @(negedge mclk);
        chk(16'(idle_mode), 16'h1);
        chk(16'(miso_oe), 16'h0);
        @(posedge mclk) spi.slave_select_n <= 1'b0;
      end
      wait_ready(12 * (32 << d) + 200);
      read16(rd);
      chk(rd, ex);
      $display("measure code %0d done", d);
    end
    // Undefined axes park with ready low and no drive; oscillator test runs with its direction
    for (int i = 0; i < 3; i++) begin
      send_cmd(i == 0 ? 8'h00 : i == 1 ? 8'h03 : 8'h0d);
      tick(400);
      @(negedge mclk);
      chk(16'({result_ready, osc_drive}), i == 2 ? 16'h0005 : 16'h0000);
    end
    @(posedge mclk) meas_reset <= 1'b1;
    @(posedge mclk) meas_reset <= 1'b0;
    @(negedge mclk);
    chk(16'(osc_drive), 16'h0);
    @(posedge mclk) spi.slave_select_n <= 1'b1;
    tick(2);
    @(negedge mclk);
    chk(16'(miso_oe), 16'h0);
    $display("parking and deselect done");
    end_sim;
  end

  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      end_sim;
    end
  end
endmodule
